// File: core/res_pkg.sv
// package: register map, field layout, decode and timing constants
// assumes: 20 MHz system clock, 8-bit register port
package res_pkg;
  typedef logic [7:0]  res_byte_t;
  typedef logic [11:0] res_mv_t;
  typedef logic [4:0]  res_wait_t;

  typedef struct packed {
    logic [4:0] spare;
    logic       discharge;
    logic       gating;
    logic       on;
  } res_ctrl_t;

  typedef struct packed {
    logic [3:0] fall_wait;
    logic [3:0] rise_wait;
  } res_dly_t;

  localparam res_byte_t ADDR_CONV1_VOLT = 8'h07;
  localparam res_byte_t ADDR_LDO0_MODE  = 8'h08;
  localparam res_byte_t ADDR_LDO1_MODE  = 8'h09;
  localparam res_byte_t ADDR_LDO0_VOLT  = 8'h0A;
  localparam res_byte_t ADDR_LDO1_VOLT  = 8'h0B;
  localparam res_byte_t ADDR_CONV0_DLY  = 8'h0C;
  localparam res_byte_t ADDR_CONV1_DLY  = 8'h0D;
  localparam res_byte_t ADDR_LDO0_DLY   = 8'h0E;
  localparam res_byte_t ADDR_CONFIG     = 8'h13;

  localparam int        CFG_RISE_LONG = 6;
  localparam int        CFG_FALL_LONG = 5;
  localparam res_byte_t CTRL_RESET    = 8'h04;
  localparam res_byte_t VOLT_RESET    = 8'h00;
  localparam res_byte_t DLY_RESET     = 8'h00;
  localparam res_byte_t CFG_RESET     = 8'h00;

  localparam res_byte_t CONV_B1_LO  = 8'h14;
  localparam res_byte_t CONV_B1_HI  = 8'h17;
  localparam res_byte_t CONV_B2_LO  = 8'h18;
  localparam res_byte_t CONV_B2_HI  = 8'h9D;
  localparam res_byte_t CONV_B3_LO  = 8'h9E;
  localparam res_mv_t   MV_B1_BASE  = 12'h2BC;
  localparam res_mv_t   MV_B1_STEP  = 12'h00A;
  localparam res_mv_t   MV_B2_BASE  = 12'h2DF;
  localparam res_mv_t   MV_B2_STEP  = 12'h005;
  localparam res_mv_t   MV_B3_BASE  = 12'h58C;
  localparam res_mv_t   MV_B3_STEP  = 12'h014;
  localparam logic [4:0] LDO_HI     = 5'h19;
  localparam res_mv_t   MV_LDO_BASE = 12'h320;
  localparam res_mv_t   MV_LDO_STEP = 12'h064;

  localparam int CLK_HZ         = 20000000;
  localparam int STEP_US        = 500;
  localparam int HALF_MS_CYCLES = CLK_HZ / 1000000 * STEP_US;

  function automatic res_mv_t conv_mv(input res_byte_t c);
    if (c < CONV_B1_LO)
      return 12'h000;
    if (c <= CONV_B1_HI)
      return MV_B1_BASE + MV_B1_STEP * 12'(c - CONV_B1_LO);
    if (c <= CONV_B2_HI)
      return MV_B2_BASE + MV_B2_STEP * 12'(c - CONV_B2_LO);
    return MV_B3_BASE + MV_B3_STEP * 12'(c - CONV_B3_LO);
  endfunction

  function automatic res_mv_t ldo_mv(input logic [4:0] c);
    if (c > LDO_HI)
      return 12'h000;
    return MV_LDO_BASE + MV_LDO_STEP * 12'(c);
  endfunction

  // wait in half-millisecond ticks; long range doubles the step
  function automatic res_wait_t wait_len(input logic [3:0] c,
                                         input logic       long_rng);
    return long_rng ? {c, 1'b0} : {1'b0, c};
  endfunction
endpackage

// File: core/res_pin_sync.sv
// enable pin synchroniser with edge pulses
// assumes: pin is asynchronous to the system clock
`timescale 1ns/1ps
`default_nettype none
module res_pin_sync (
  input  wire logic i_sys_clk,
  input  wire logic i_rst,
  input  wire logic i_ce,
  input  wire logic i_pin,
  output var  logic o_level,
  output var  logic o_rise,
  output var  logic o_fall
);
  logic s1_reg;
  logic s2_reg;
  logic s3_reg;
  logic level_reg;

  // ------------------------------------------------------------
  // three stages, accept once stages two and three agree
  // ------------------------------------------------------------
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
    end else if (i_ce) begin
      s1_reg <= i_pin;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      level_reg <= 1'b0;
      o_rise    <= 1'b0;
      o_fall    <= 1'b0;
    end else if (i_ce) begin
      o_rise <= (s2_reg == s3_reg) && s3_reg && !level_reg;
      o_fall <= (s2_reg == s3_reg) && !s3_reg && level_reg;
      if (s2_reg == s3_reg)
        level_reg <= s3_reg;
    end
  end

  assign o_level = level_reg;

  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);

  a_sync_agree: assert property (
    (i_ce && s2_reg == s3_reg && s3_reg != level_reg)
      |=> (level_reg == $past(s3_reg)) && (o_rise || o_fall))
    else $error("enable level did not follow agreed stages");
endmodule
`default_nettype wire

// File: core/res_delay_unit.sv
// one rail's startup and shutdown delay from enable edges
// assumes: edge pulses and half-ms ticks from the parent
`timescale 1ns/1ps
`default_nettype none
module res_delay_unit
  import res_pkg::*;
(
  input  wire logic               i_sys_clk,
  input  wire logic               i_rst,
  input  wire logic               i_ce,
  input  wire logic               i_rise,
  input  wire logic               i_fall,
  input  wire logic               i_tick,
  input  wire res_pkg::res_wait_t i_rise_wait,
  input  wire res_pkg::res_wait_t i_fall_wait,
  output var  logic               o_on
);
  typedef enum logic [1:0] {
    ST_OFF, ST_RISE_WAIT, ST_ON, ST_FALL_WAIT
  } res_dly_state_t;

  res_dly_state_t state_reg;
  res_wait_t      cnt_reg;
  logic           waiting;
  logic           done;

  assign waiting = (state_reg == ST_RISE_WAIT) ||
                   (state_reg == ST_FALL_WAIT);
  assign done    = waiting && i_tick && (cnt_reg == 5'h01);

  // ------------------------------------------------------------
  // sequence state and tick counter
  // ------------------------------------------------------------
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      state_reg <= ST_OFF;
      cnt_reg   <= 5'h00;
    end else if (i_ce) begin
      if (i_rise) begin
        state_reg <= (i_rise_wait == 5'h00) ? ST_ON : ST_RISE_WAIT;
        cnt_reg   <= i_rise_wait;
      end else if (i_fall) begin
        state_reg <= (i_fall_wait == 5'h00) ? ST_OFF : ST_FALL_WAIT;
        cnt_reg   <= i_fall_wait;
      end else if (waiting && i_tick) begin
        cnt_reg <= cnt_reg - 5'h01;
        unique case (state_reg)
          ST_RISE_WAIT: if (done) state_reg <= ST_ON;
          ST_FALL_WAIT: if (done) state_reg <= ST_OFF;
          ST_OFF, ST_ON: state_reg <= state_reg;
        endcase
      end
    end
  end

  // ------------------------------------------------------------
  // rail output
  // ------------------------------------------------------------
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_on <= 1'b0;
    end else if (i_ce) begin
      if (i_rise && i_rise_wait == 5'h00)
        o_on <= 1'b1;
      else if (i_fall && i_fall_wait == 5'h00)
        o_on <= 1'b0;
      else if (!i_rise && !i_fall && done)
        o_on <= (state_reg == ST_RISE_WAIT);
    end
  end

  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);

  sequence s_rise_loaded;
    (i_ce && i_rise && i_rise_wait != 5'h00) ##1 (state_reg == ST_RISE_WAIT);
  endsequence

  a_rise_load_count: assert property (
    s_rise_loaded |-> cnt_reg == $past(i_rise_wait))
    else $error("startup wait not loaded");
  a_rise_end_on: assert property (
    (i_ce && done && state_reg == ST_RISE_WAIT && !i_rise && !i_fall)
      |=> o_on)
    else $error("rail not on after startup wait");
  a_fall_end_off: assert property (
    (i_ce && done && state_reg == ST_FALL_WAIT && !i_rise && !i_fall)
      |=> !o_on)
    else $error("rail not off after shutdown wait");
endmodule
`default_nettype wire

// File: core/res_rail_sequencer.sv
// rail enable sequencer: voltage decode, regulator gating, delays
// assumes: register port driven by the serial interface logic,
//          enable pin asynchronous, 20 MHz clock
`timescale 1ns/1ps
`default_nettype none
module res_rail_sequencer
  import res_pkg::*;
#(
  parameter int HALF_MS = HALF_MS_CYCLES
) (
  input  wire logic              i_sys_clk,
  input  wire logic              i_rst,
  input  wire logic              i_ce,
  input  wire logic              i_en_pin,
  input  wire logic              i_reg_wr,
  input  wire res_pkg::res_byte_t i_reg_addr,
  input  wire res_pkg::res_byte_t i_reg_wdata,
  output var  res_pkg::res_byte_t o_reg_rdata,
  output var  logic              o_conv0_on,
  output var  logic              o_conv1_on,
  output var  logic              o_ldo0_on,
  output var  logic              o_ldo1_on,
  output var  logic              o_ldo0_discharge,
  output var  logic              o_ldo1_discharge,
  output var  res_pkg::res_mv_t   o_conv1_mv,
  output var  res_pkg::res_mv_t   o_ldo0_mv,
  output var  res_pkg::res_mv_t   o_ldo1_mv
);
  localparam int PRE_W = $clog2(HALF_MS);
  localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(HALF_MS - 1);

  res_byte_t conv1_volt_reg;
  res_ctrl_t ldo0_mode_reg;
  res_ctrl_t ldo1_mode_reg;
  res_byte_t ldo0_volt_reg;
  res_byte_t ldo1_volt_reg;
  res_dly_t  conv0_dly_reg;
  res_dly_t  conv1_dly_reg;
  res_dly_t  ldo0_dly_reg;
  res_byte_t config_reg;
  res_byte_t rdata_next;

  logic             pin_level;
  logic             pin_rise;
  logic             pin_fall;
  logic [PRE_W-1:0] pre_cnt_reg;
  logic             tick;
  logic             rise_long;
  logic             fall_long;
  logic             ldo0_seq;
  logic             ldo0_want;
  logic             ldo1_want;

  // ------------------------------------------------------------
  // enable pin synchroniser
  // ------------------------------------------------------------
  res_pin_sync u_pin_sync (
    .i_sys_clk (i_sys_clk),
    .i_rst     (i_rst),
    .i_ce      (i_ce),
    .i_pin     (i_en_pin),
    .o_level   (pin_level),
    .o_rise    (pin_rise),
    .o_fall    (pin_fall)
  );

  // ------------------------------------------------------------
  // register writes
  // ------------------------------------------------------------
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      conv1_volt_reg <= VOLT_RESET;
      ldo0_mode_reg  <= CTRL_RESET;
      ldo1_mode_reg  <= CTRL_RESET;
      ldo0_volt_reg  <= VOLT_RESET;
      ldo1_volt_reg  <= VOLT_RESET;
      conv0_dly_reg  <= DLY_RESET;
      conv1_dly_reg  <= DLY_RESET;
      ldo0_dly_reg   <= DLY_RESET;
      config_reg     <= CFG_RESET;
    end else if (i_ce && i_reg_wr) begin
      unique case (i_reg_addr)
        ADDR_CONV1_VOLT: begin
          conv1_volt_reg <= i_reg_wdata;
        end
        ADDR_LDO0_MODE: begin
          ldo0_mode_reg <= i_reg_wdata;
        end
        ADDR_LDO1_MODE: begin
          ldo1_mode_reg <= i_reg_wdata;
        end
        ADDR_LDO0_VOLT: begin
          ldo0_volt_reg <= i_reg_wdata;
        end
        ADDR_LDO1_VOLT: begin
          ldo1_volt_reg <= i_reg_wdata;
        end
        ADDR_CONV0_DLY: begin
          conv0_dly_reg <= i_reg_wdata;
        end
        ADDR_CONV1_DLY: begin
          conv1_dly_reg <= i_reg_wdata;
        end
        ADDR_LDO0_DLY: begin
          ldo0_dly_reg <= i_reg_wdata;
        end
        ADDR_CONFIG: begin
          config_reg <= i_reg_wdata;
        end
        default: begin
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // register reads
  // ------------------------------------------------------------
  always_comb begin
    rdata_next = 8'h00;
    unique case (i_reg_addr)
      ADDR_CONV1_VOLT: rdata_next = conv1_volt_reg;
      ADDR_LDO0_MODE:  rdata_next = ldo0_mode_reg;
      ADDR_LDO1_MODE:  rdata_next = ldo1_mode_reg;
      ADDR_LDO0_VOLT:  rdata_next = ldo0_volt_reg;
      ADDR_LDO1_VOLT:  rdata_next = ldo1_volt_reg;
      ADDR_CONV0_DLY:  rdata_next = conv0_dly_reg;
      ADDR_CONV1_DLY:  rdata_next = conv1_dly_reg;
      ADDR_LDO0_DLY:   rdata_next = ldo0_dly_reg;
      ADDR_CONFIG:     rdata_next = config_reg;
      default:         rdata_next = 8'h00;
    endcase
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_reg_rdata <= 8'h00;
    end else if (i_ce) begin
      o_reg_rdata <= rdata_next;
    end
  end

  // ------------------------------------------------------------
  // voltage decode
  // ------------------------------------------------------------
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_conv1_mv <= 12'h000;
      o_ldo0_mv  <= 12'h000;
      o_ldo1_mv  <= 12'h000;
    end else if (i_ce) begin
      // reserved codes decode to zero
      o_conv1_mv <= conv_mv(conv1_volt_reg);
      o_ldo0_mv  <= ldo_mv(ldo0_volt_reg[4:0]);
      o_ldo1_mv  <= ldo_mv(ldo1_volt_reg[4:0]);
    end
  end

  // ------------------------------------------------------------
  // common half-millisecond timebase
  // ------------------------------------------------------------
  // restarted on every pin edge so each wait is exact from the edge
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      pre_cnt_reg <= '0;
    end else if (i_ce) begin
      if (pin_rise || pin_fall)
        pre_cnt_reg <= '0;
      else if (pre_cnt_reg == PRE_LAST)
        pre_cnt_reg <= '0;
      else
        pre_cnt_reg <= pre_cnt_reg + PRE_W'(1);
    end
  end

  assign tick = (pre_cnt_reg == PRE_LAST) && !pin_rise && !pin_fall;

  assign rise_long = config_reg[CFG_RISE_LONG];
  assign fall_long = config_reg[CFG_FALL_LONG];

  // ------------------------------------------------------------
  // per-rail delays
  // ------------------------------------------------------------
  res_delay_unit u_conv0_dly (
    .i_sys_clk   (i_sys_clk),
    .i_rst       (i_rst),
    .i_ce        (i_ce),
    .i_rise      (pin_rise),
    .i_fall      (pin_fall),
    .i_tick      (tick),
    .i_rise_wait (wait_len(conv0_dly_reg.rise_wait, rise_long)),
    .i_fall_wait (wait_len(conv0_dly_reg.fall_wait, fall_long)),
    .o_on        (o_conv0_on)
  );

  res_delay_unit u_conv1_dly (
    .i_sys_clk   (i_sys_clk),
    .i_rst       (i_rst),
    .i_ce        (i_ce),
    .i_rise      (pin_rise),
    .i_fall      (pin_fall),
    .i_tick      (tick),
    .i_rise_wait (wait_len(conv1_dly_reg.rise_wait, rise_long)),
    .i_fall_wait (wait_len(conv1_dly_reg.fall_wait, fall_long)),
    .o_on        (o_conv1_on)
  );

  res_delay_unit u_ldo0_dly (
    .i_sys_clk   (i_sys_clk),
    .i_rst       (i_rst),
    .i_ce        (i_ce),
    .i_rise      (pin_rise),
    .i_fall      (pin_fall),
    .i_tick      (tick),
    .i_rise_wait (wait_len(ldo0_dly_reg.rise_wait, rise_long)),
    .i_fall_wait (wait_len(ldo0_dly_reg.fall_wait, fall_long)),
    .o_on        (ldo0_seq)
  );

  // ------------------------------------------------------------
  // linear regulator enables and discharge
  // ------------------------------------------------------------
  assign ldo0_want = ldo0_mode_reg.on &&
                     (!ldo0_mode_reg.gating || ldo0_seq);
  assign ldo1_want = ldo1_mode_reg.on &&
                     (!ldo1_mode_reg.gating || pin_level);

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_ldo0_on <= 1'b0;
      o_ldo1_on <= 1'b0;
    end else if (i_ce) begin
      o_ldo0_on <= ldo0_want;
      o_ldo1_on <= ldo1_want;
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_ldo0_discharge <= 1'b0;
      o_ldo1_discharge <= 1'b0;
    end else if (i_ce) begin
      o_ldo0_discharge <= !ldo0_want && ldo0_mode_reg.discharge;
      o_ldo1_discharge <= !ldo1_want && ldo1_mode_reg.discharge;
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);

  sequence s_ldo0_closed;
    i_ce && ldo0_mode_reg.gating && !ldo0_seq;
  endsequence

  sequence s_ldo0_open;
    i_ce && ldo0_mode_reg.gating && ldo0_seq;
  endsequence

  sequence s_ldo0_free;
    i_ce && !ldo0_mode_reg.gating;
  endsequence

  a_conv_band_one: assert property (
    (i_ce && conv1_volt_reg inside {[8'h14:8'h17]})
      |=> o_conv1_mv == 12'h2BC
                        + 12'h00A * 12'($past(conv1_volt_reg) - 8'h14))
    else $error("converter band one decode wrong");

  a_conv_band_two: assert property (
    (i_ce && conv1_volt_reg inside {[8'h18:8'h9D]})
      |=> o_conv1_mv == 12'h2DF
                        + 12'h005 * 12'($past(conv1_volt_reg) - 8'h18))
    else $error("converter band two decode wrong");

  a_conv_band_three: assert property (
    (i_ce && conv1_volt_reg >= 8'h9E)
      |=> o_conv1_mv == 12'h58C
                        + 12'h014 * 12'($past(conv1_volt_reg) - 8'h9E))
    else $error("converter band three decode wrong");

  a_ldo_volt_map: assert property (
    (i_ce && ldo0_volt_reg[4:0] <= 5'h19)
      |=> o_ldo0_mv == 12'h320 + 12'h064 * 12'($past(ldo0_volt_reg[4:0])))
    else $error("linear 0 voltage decode wrong");

  a_ldo1_volt_map: assert property (
    (i_ce && ldo1_volt_reg[4:0] <= 5'h19)
      |=> o_ldo1_mv == 12'h320 + 12'h064 * 12'($past(ldo1_volt_reg[4:0])))
    else $error("linear 1 voltage decode wrong");

  a_ldo0_dis_gate: assert property (
    ##1 (i_ce && $past(i_ce))
      |-> o_ldo0_discharge == (!o_ldo0_on && $past(ldo0_mode_reg.discharge)))
    else $error("linear 0 discharge wrong");

  a_ldo1_dis_gate: assert property (
    ##1 (i_ce && $past(i_ce))
      |-> o_ldo1_discharge == (!o_ldo1_on && $past(ldo1_mode_reg.discharge)))
    else $error("linear 1 discharge wrong");

  a_ldo0_gate_shut: assert property (
    s_ldo0_closed |=> !o_ldo0_on)
    else $error("linear 0 on while pin gate closed");

  a_ldo0_gate_open: assert property (
    s_ldo0_open |=> o_ldo0_on == $past(ldo0_mode_reg.on))
    else $error("linear 0 wrong while pin gate open");

  a_ldo0_bit_only: assert property (
    s_ldo0_free |=> o_ldo0_on == $past(ldo0_mode_reg.on))
    else $error("linear 0 does not follow its bit");

  a_ldo1_pin_and: assert property (
    (i_ce && ldo1_mode_reg.gating)
      |=> o_ldo1_on == ($past(ldo1_mode_reg.on) && $past(pin_level)))
    else $error("linear 1 pin gating wrong");

  a_ldo1_bit_only: assert property (
    (i_ce && !ldo1_mode_reg.gating)
      |=> o_ldo1_on == $past(ldo1_mode_reg.on))
    else $error("linear 1 does not follow its bit");

  a_edge_restart: assert property (
    (i_ce && (pin_rise || pin_fall)) |=> pre_cnt_reg == '0 && !tick)
    else $error("timebase not restarted on edge");
endmodule
`default_nettype wire

// File: verif/res_host_model.sv
// host model: drives the enable pin and the register port
// assumes: tasks are called at the falling clock edge
`timescale 1ns/1ps
`default_nettype none
module res_host_model
  import res_pkg::*;
(
  input  wire logic               i_sys_clk,
  output var  logic               o_en_pin,
  output var  logic               o_reg_wr,
  output var  res_pkg::res_byte_t o_reg_addr,
  output var  res_pkg::res_byte_t o_reg_wdata
);
  // --------
  // host tasks
  // --------
  initial begin
    o_en_pin    = 1'b0;
    o_reg_wr    = 1'b0;
    o_reg_addr  = 8'h00;
    o_reg_wdata = 8'h00;
  end
  // one byte write, skipped for reserved voltage codes; strobe low for a full cycle after it
  task automatic wr(input res_byte_t a, input res_byte_t d);
    if (a == ADDR_CONV1_VOLT && d < CONV_B1_LO) return;
    if ((a == ADDR_LDO0_VOLT || a == ADDR_LDO1_VOLT) && d[4:0] > LDO_HI)
      return;
    o_reg_addr  = a;
    o_reg_wdata = d;
    o_reg_wr    = 1'b1;
    @(negedge i_sys_clk);
    o_reg_wr    = 1'b0;
    @(negedge i_sys_clk);
  endtask
  task automatic sel(input res_byte_t a);
    o_reg_addr = a;
  endtask
  task automatic pin(input logic v);
    o_en_pin = v;
  endtask
endmodule
`default_nettype wire

// File: verif/tb_rail_enable_sequencer.sv
// testbench: rail sequencer driven by the host model
// assumes: short half-millisecond count, fixed random seed
`timescale 1ns/1ps
`default_nettype none
`define CHK(s, e, g) begin cmp_count++; if ((g) !== (e)) begin \
  num_errors++; $display("BAD %s exp %h got %h", s, e, g); end end
module tb_rail_enable_sequencer;
  import res_pkg::*;
  typedef struct {int sel; logic [11:0] e;} res_note_t;
  localparam int HM = 8;
  logic      clk = 1'b0;
  logic      rst, ce, en_pin, wr, c0, c1, l0, l1, d0, d1;
  res_byte_t addr, wdata, rdata;
  res_mv_t   mv_c1, mv_l0, mv_l1;
  int        num_errors = 0;
  int        cmp_count = 0;
  res_note_t q [$];
  res_note_t n;
  string     nm [10] = '{"rdata", "conv0", "conv1", "ldo0", "ldo1",
                         "dis0", "dis1", "mv_c1", "mv_l0", "mv_l1"};
  int        bnd [6] = '{20, 23, 24, 157, 158, 255};
  res_byte_t da [3] = '{ADDR_CONV0_DLY, ADDR_CONV1_DLY, ADDR_LDO0_DLY};

  always #25 clk = ~clk;

  res_rail_sequencer #(.HALF_MS(HM)) uut (
    .i_sys_clk(clk), .i_rst(rst), .i_ce(ce), .i_en_pin(en_pin),
    .i_reg_wr(wr), .i_reg_addr(addr), .i_reg_wdata(wdata),
    .o_reg_rdata(rdata), .o_conv0_on(c0), .o_conv1_on(c1),
    .o_ldo0_on(l0), .o_ldo1_on(l1), .o_ldo0_discharge(d0),
    .o_ldo1_discharge(d1), .o_conv1_mv(mv_c1), .o_ldo0_mv(mv_l0),
    .o_ldo1_mv(mv_l1));
  res_host_model host (.i_sys_clk(clk), .o_en_pin(en_pin),
    .o_reg_wr(wr), .o_reg_addr(addr), .o_reg_wdata(wdata));

  // --------
  // notes and checking
  // --------
  function automatic logic [11:0] obs(input int s);
    case (s)
      0: return {4'h0, rdata};
      1: return {11'h000, c0};
      2: return {11'h000, c1};
      3: return {11'h000, l0};
      4: return {11'h000, l1};
      5: return {11'h000, d0};
      6: return {11'h000, d1};
      7: return mv_c1;
      8: return mv_l0;
      default: return mv_l1;
    endcase
  endfunction
  function automatic logic [11:0] cmv(input int c);
    if (c <= 23) return 12'(700 + 10 * (c - 20));
    if (c <= 157) return 12'(735 + 5 * (c - 24));
    return 12'(1420 + 20 * (c - 158));
  endfunction
  task automatic note(input int s, input logic [11:0] e);
    q.push_back('{s, e});
  endtask
  // values settled since the last falling edge are seen here
  always @(posedge clk) begin
    while (q.size() > 0) begin
      n = q.pop_front();
      `CHK(nm[n.sel], n.e, obs(n.sel))
    end
  end
  task automatic final_report();
    if (num_errors == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // one pin edge; rail r must change exactly after its wait
  task automatic seq(input logic v, input int r, input int w);
    int m;
    m = 4 + HM * w + ((r == 2) ? 1 : 0);
    host.pin(v);
    repeat (m) @(negedge clk);
    note(r + 1, {11'h000, !v});
    if (r == 2) note(5, {11'h000, v});
    @(negedge clk);
    note(r + 1, {11'h000, v});
    if (r == 2) note(5, {11'h000, !v});
  endtask
  initial begin
    repeat (100000) @(posedge clk);
    num_errors++;
    final_report();
  end

  // --------
  // stimulus
  // --------
  initial begin
    int c, lv, r;
    logic lr, lf, on, g, d, p;
    logic [3:0] cr, cf;
    logic [7:0] v;
    void'($urandom(32'h95EB054A));
    rst = 1'b1;
    ce  = 1'b1;
    repeat (5) @(negedge clk);
    rst = 1'b0;
    for (int i = 0; i < 21; i++) begin
      host.sel(8'(i));
      @(negedge clk);
      note(0, (i == 8 || i == 9) ? 12'h004 : 12'h000);
    end
    note(5, 12'h001);
    note(6, 12'h001);
    note(8, 12'h320);
    for (int k = 0; k < 16; k++) begin
      c  = (k < 6) ? bnd[k] : $urandom_range(255, 20);
      lv = (k < 2) ? 25 * k : $urandom_range(25, 0);
      v  = {3'($urandom), 5'(lv)};
      host.wr(ADDR_CONV1_VOLT, 8'(c));
      host.wr(ADDR_LDO0_VOLT, v);
      host.wr(ADDR_LDO1_VOLT, 8'(25 - lv));
      host.sel(ADDR_LDO0_VOLT);
      @(negedge clk);
      note(0, {4'h0, v});
      note(7, cmv(c));
      note(8, 12'(800 + 100 * lv));
      note(9, 12'(800 + 100 * (25 - lv)));
    end
    // a write while the clock enable is low must not land
    ce = 1'b0;
    host.wr(ADDR_CONV1_VOLT, 8'h20);
    ce = 1'b1;
    host.sel(ADDR_CONV1_VOLT);
    @(negedge clk);
    note(0, {4'h0, 8'(c)});
    note(7, cmv(c));
    for (int k = 0; k < 16; k++) begin
      {on, g, d, p} = 4'(k);
      host.pin(p);
      repeat (6) @(negedge clk);
      host.wr(ADDR_LDO1_MODE, {5'h00, d, g, on});
      host.wr(ADDR_LDO0_MODE, {5'h00, d, 1'b0, on});
      note(4, {11'h000, on & (!g | p)});
      note(6, {11'h000, !(on & (!g | p)) & d});
      note(3, {11'h000, on});
      note(5, {11'h000, !on & d});
    end
    host.wr(ADDR_LDO0_MODE, 8'h07);
    host.pin(1'b0);
    for (int k = 0; k < 12; k++) begin
      repeat (300) @(negedge clk);
      r  = k % 3;
      cr = (k < 3) ? 4'hF : (k < 6) ? 4'h0 : 4'($urandom);
      cf = (k < 3) ? 4'hF : (k < 6) ? 4'h1 : 4'($urandom);
      lr = (k < 3) ? 1'b1 : (k < 6) ? 1'b0 : 1'($urandom);
      lf = (k < 3) ? 1'b1 : (k < 6) ? 1'b0 : 1'($urandom);
      host.wr(ADDR_CONFIG, {1'b0, lr, lf, 5'h00});
      host.wr(da[r], {cf, cr});
      seq(1'b1, r, lr ? 2 * cr : cr);
      repeat (4) @(negedge clk);
      seq(1'b0, r, lf ? 2 * cf : cf);
    end
    repeat (2) @(negedge clk);
    final_report();
  end
endmodule
`default_nettype wire
